//--- core/psm_pkg.sv
// Constants, types and register map of the peripheral pin select mux.
// Assumes an APB master, port logic and peripherals all on clk_sys.
// =====================================================================
// Functional notes
// - Lock bit set blocks all selector writes
// - Power-on defaults for irq, timer, waveform inputs
// - Converter trigger input defaults to port C bit4
// - Pin output code picks latch or peripheral
// - Waveform and serial outputs may override direction
// - Unsupported or reserved source drives constant zero
// - Field widths five, four, one; rest zero
// - Lock change needs 0x55 then 0xAA first
// - One-shot option: single clear, then stays set
// - Only power-on reset restores the selections
// - Input code: port in 4:3, bit in 2:0
package psm_pkg;

    // =================================================================
    // Sizes and fields
    localparam int NUM_IN   = 8;
    localparam int NUM_PIN  = 24;
    localparam int NUM_SRC  = 16;
    localparam int IN_W     = 5;
    localparam int OUT_W    = 4;
    localparam int PORT_LSB = 3;
    localparam int LOCK_BIT = 0;

    // =================================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_LOCK   = 8'h00;
    localparam logic [7:0] ADDR_IN_LO  = 8'h04;
    localparam logic [7:0] ADDR_IN_HI  = 8'h20;
    localparam logic [7:0] ADDR_OUT_LO = 8'h40;
    localparam logic [7:0] ADDR_OUT_HI = 8'h9C;
    localparam logic [1:0] KIND_NONE   = 2'h0;
    localparam logic [1:0] KIND_LOCK   = 2'h1;
    localparam logic [1:0] KIND_IN     = 2'h2;
    localparam logic [1:0] KIND_OUT    = 2'h3;

    // =================================================================
    // Input selector codes and power-on defaults, index 7 first
    localparam logic [1:0] PORT_RSVD    = 2'h3;
    localparam logic [4:0] DEF_EDGE     = 5'h02;
    localparam logic [4:0] DEF_T0CK     = 5'h02;
    localparam logic [4:0] DEF_T1CK     = 5'h05;
    localparam logic [4:0] DEF_T1G      = 5'h04;
    localparam logic [4:0] DEF_WAVE     = 5'h02;
    localparam logic [4:0] DEF_RX_BIG   = 5'h0D;
    localparam logic [4:0] DEF_RX_SMALL = 5'h15;
    localparam logic [4:0] DEF_CK_BIG   = 5'h0F;
    localparam logic [4:0] DEF_CK_SMALL = 5'h14;
    localparam logic [4:0] DEF_CONV     = 5'h14;
    localparam logic [NUM_IN*IN_W-1:0] IN_DEF_BIG =
        {DEF_CONV, DEF_CK_BIG, DEF_RX_BIG, DEF_WAVE, DEF_T1G, DEF_T1CK, DEF_T0CK, DEF_EDGE};
    localparam logic [NUM_IN*IN_W-1:0] IN_DEF_SMALL =
        {DEF_CONV, DEF_CK_SMALL, DEF_RX_SMALL, DEF_WAVE, DEF_T1G, DEF_T1CK, DEF_T0CK, DEF_EDGE};
    localparam logic [OUT_W-1:0] OUT_DEF = 4'h0;

    // =================================================================
    // Pin output source codes
    localparam logic [3:0] SRC_LATCH  = 4'h0;
    localparam logic [3:0] SRC_CMP1   = 4'h1;
    localparam logic [3:0] SRC_CMP2   = 4'h2;
    localparam logic [3:0] SRC_PWM1   = 4'h3;
    localparam logic [3:0] SRC_PWM2   = 4'h4;
    localparam logic [3:0] SRC_PWM3   = 4'h5;
    localparam logic [3:0] SRC_PWM4   = 4'h6;
    localparam logic [3:0] SRC_WAVE_A = 4'h7;
    localparam logic [3:0] SRC_WAVE_B = 4'h8;
    localparam logic [3:0] SRC_TXCK   = 4'h9;
    localparam logic [3:0] SRC_DT     = 4'hA;
    localparam logic [NUM_SRC-1:0] SRC_AVAIL_ALL = 16'h07FF;
    localparam int OVR_WAVE_A = 0;
    localparam int OVR_WAVE_B = 1;
    localparam int OVR_TXCK   = 2;
    localparam int OVR_DT     = 3;

    // =================================================================
    // Lock keys and pin presence, index is port * 8 + bit
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [NUM_PIN-1:0] OUT_MASK_BIG   = 24'hFFF037;
    localparam logic [NUM_PIN-1:0] OUT_MASK_SMALL = 24'h3F0037;
    localparam logic [NUM_PIN-1:0] IN_MASK_BIG    = 24'hFFF03F;
    localparam logic [NUM_PIN-1:0] IN_MASK_SMALL  = 24'h3F003F;

    // =================================================================
    // Types
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_GOT55 = 2'b01,
        SEQ_ARMED = 2'b11
    } psm_seq_e;

    typedef logic [IN_W-1:0]  psm_in_sel_t;
    typedef logic [OUT_W-1:0] psm_out_sel_t;

    typedef struct packed {
        logic       cmp1;
        logic       cmp2;
        logic [3:0] pwm;
        logic       wave_a;
        logic       wave_b;
        logic       txck;
        logic       dt;
        logic [3:0] ovr;
        logic [3:0] ovr_oe;
    } psm_periph_out_s;

    typedef struct packed {
        logic conv_trig;
        logic ser_ck;
        logic ser_rx;
        logic wave_in;
        logic t1_gate;
        logic t1_clk;
        logic t0_clk;
        logic edge_irq;
    } psm_periph_in_s;

    typedef struct packed {
        psm_seq_e                   seq;
        logic                       locked;
        logic                       clr_used;
        psm_in_sel_t [NUM_IN-1:0]   in_sel;
        psm_out_sel_t [NUM_PIN-1:0] out_sel;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic [NUM_PIN-1:0]         pin_out;
        logic [NUM_PIN-1:0]         pin_oe;
    } psm_top_s;

    typedef struct packed {
        logic [NUM_PIN-1:0] sync1;
        logic [NUM_PIN-1:0] sync2;
        psm_periph_in_s     routed;
    } psm_route_s;

endpackage

//--- core/psm_in_route.sv
// Input side of the pin select mux: pin synchronisers and per-peripheral
// input routing. Assumes pins are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module psm_in_route
    import psm_pkg::*;
#(
    parameter logic BIG_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // Pins and selectors
    input  wire logic [NUM_PIN-1:0]       pin_in,
    input  wire psm_in_sel_t [NUM_IN-1:0] in_sel,
    // Routed peripheral inputs
    output psm_periph_in_s                periph_in
);

    localparam logic [NUM_PIN-1:0] IN_MASK = BIG_VARIANT ? IN_MASK_BIG : IN_MASK_SMALL;

    psm_route_s st_reg;
    psm_route_s st_next;

    // =================================================================
    // Selector decode; absent pins and the reserved port read low
    function automatic logic route(input psm_in_sel_t sel, input logic [NUM_PIN-1:0] pins);
        logic [4:0] idx;
        idx = sel;
        if (sel[IN_W-1:PORT_LSB] == PORT_RSVD) begin
            return 1'b0;
        end
        return pins[idx] & IN_MASK[idx];
    endfunction

    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        for (int i = 0; i < NUM_IN; i++) begin
            st_next.routed[i] = route(in_sel[i], st_reg.sync2);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign periph_in = st_reg.routed;

endmodule // psm_in_route
`default_nettype wire

//--- core/psm_top.sv
// Peripheral pin select mux: APB register file, lock with unlock
// sequence, output source muxing per pin and input routing.
// Assumes port latch, direction and peripheral signals on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module psm_top
    import psm_pkg::*;
#(
    parameter logic               BIG_VARIANT = 1'b1,
    parameter logic [NUM_SRC-1:0] SRC_AVAIL   = SRC_AVAIL_ALL
) (
    // Clock and resets
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 soft_reset,
    // Configuration
    input  wire logic                 one_shot_lock_option,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Device pins
    input  wire logic [NUM_PIN-1:0]   pin_in,
    output logic [NUM_PIN-1:0]        pin_out,
    output logic [NUM_PIN-1:0]        pin_oe,
    // Port logic
    input  wire logic [NUM_PIN-1:0]   port_latch_bit,
    input  wire logic [NUM_PIN-1:0]   pin_direction_control,
    // Peripherals
    input  wire psm_periph_out_s      periph_out,
    output psm_periph_in_s            periph_in
);

    localparam logic [NUM_PIN-1:0] OUT_MASK = BIG_VARIANT ? OUT_MASK_BIG : OUT_MASK_SMALL;
    localparam logic [NUM_IN*IN_W-1:0] IN_DEF = BIG_VARIANT ? IN_DEF_BIG : IN_DEF_SMALL;

    psm_top_s   st_reg;
    psm_top_s   st_next;
    logic [1:0] kind;
    logic [7:0] in_off;
    logic [7:0] out_off;
    logic [2:0] in_idx;
    logic [4:0] out_idx;
    logic       access;
    logic       commit;

    // =================================================================
    // Address decode
    function automatic logic [1:0] decode(input logic [7:0] a);
        logic [7:0] off;
        off = a - ADDR_OUT_LO;
        if (a[1:0] != 2'h0) begin
            return KIND_NONE;
        end
        if (a == ADDR_LOCK) begin
            return KIND_LOCK;
        end
        if (a >= ADDR_IN_LO && a <= ADDR_IN_HI) begin
            return KIND_IN;
        end
        if (a >= ADDR_OUT_LO && a <= ADDR_OUT_HI && OUT_MASK[off[6:2]]) begin
            return KIND_OUT;
        end
        return KIND_NONE;
    endfunction

    // =================================================================
    // Output source mux for one pin, returns {oe, value}
    function automatic logic [1:0] drive(
        input psm_out_sel_t    code,
        input logic            lat,
        input logic            dir_in,
        input psm_periph_out_s po
    );
        logic v;
        logic oe;
        v  = 1'b0;
        oe = ~dir_in;
        case (code)
            SRC_LATCH:  v = lat;
            SRC_CMP1:   v = po.cmp1;
            SRC_CMP2:   v = po.cmp2;
            SRC_PWM1:   v = po.pwm[0];
            SRC_PWM2:   v = po.pwm[1];
            SRC_PWM3:   v = po.pwm[2];
            SRC_PWM4:   v = po.pwm[3];
            SRC_WAVE_A: begin
                v = po.wave_a;
                if (po.ovr[OVR_WAVE_A]) begin
                    oe = po.ovr_oe[OVR_WAVE_A];
                end
            end
            SRC_WAVE_B: begin
                v = po.wave_b;
                if (po.ovr[OVR_WAVE_B]) begin
                    oe = po.ovr_oe[OVR_WAVE_B];
                end
            end
            SRC_TXCK: begin
                v = po.txck;
                if (po.ovr[OVR_TXCK]) begin
                    oe = po.ovr_oe[OVR_TXCK];
                end
            end
            SRC_DT: begin
                v = po.dt;
                if (po.ovr[OVR_DT]) begin
                    oe = po.ovr_oe[OVR_DT];
                end
            end
            default: v = 1'b0;
        endcase
        // Reserved codes are cleared in SRC_AVAIL as well
        if (!SRC_AVAIL[code]) begin
            v = 1'b0;
        end
        return {oe, v};
    endfunction

    // =================================================================
    // Bus phase decode
    always_comb begin
        kind    = decode(paddr);
        in_off  = paddr - ADDR_IN_LO;
        out_off = paddr - ADDR_OUT_LO;
        in_idx  = in_off[4:2];
        out_idx = out_off[6:2];
        access  = psel && penable;
        // The answer is registered, so every access has one wait state
        commit  = access && st_reg.pready && pwrite && !st_reg.pslverr;
    end

    // =================================================================
    // Next state
    always_comb begin
        st_next = st_reg;

        // Read data and the ready answer
        if (access && !st_reg.pready) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = (kind == KIND_NONE);
            st_next.prdata  = '0;
            unique case (kind)
                KIND_LOCK: st_next.prdata[LOCK_BIT] = st_reg.locked;
                KIND_IN:   st_next.prdata[IN_W-1:0] = st_reg.in_sel[in_idx];
                KIND_OUT:  st_next.prdata[OUT_W-1:0] = st_reg.out_sel[out_idx];
                KIND_NONE: st_next.prdata = '0;
            endcase
        end else begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata  = '0;
        end

        // Register writes
        if (commit) begin
            unique case (kind)
                KIND_LOCK: begin
                    unique case (st_reg.seq)
                        SEQ_IDLE: begin
                            if (pwdata[7:0] == KEY_FIRST) begin
                                st_next.seq = SEQ_GOT55;
                            end
                        end
                        SEQ_GOT55: begin
                            if (pwdata[7:0] == KEY_SECOND) begin
                                st_next.seq = SEQ_ARMED;
                            end else if (pwdata[7:0] != KEY_FIRST) begin
                                st_next.seq = SEQ_IDLE;
                            end
                        end
                        SEQ_ARMED: begin
                            st_next.seq = SEQ_IDLE;
                            if (pwdata[LOCK_BIT]) begin
                                st_next.locked = 1'b1;
                            end else if (!(one_shot_lock_option && st_reg.clr_used)) begin
                                // Only a real clear uses up the one chance
                                if (st_reg.locked) begin
                                    st_next.clr_used = one_shot_lock_option;
                                end
                                st_next.locked = 1'b0;
                            end
                        end
                        default: st_next.seq = SEQ_IDLE;
                    endcase
                end
                KIND_IN: begin
                    if (!st_reg.locked) begin
                        st_next.in_sel[in_idx] = pwdata[IN_W-1:0];
                    end
                end
                KIND_OUT: begin
                    if (!st_reg.locked) begin
                        st_next.out_sel[out_idx] = pwdata[OUT_W-1:0];
                    end
                end
                KIND_NONE: st_next.seq = SEQ_IDLE;
            endcase
            // Any write to a selector register breaks the unlock sequence; refused unmapped writes do not
            if (kind != KIND_LOCK) begin
                st_next.seq = SEQ_IDLE;
            end
        end

        // Pin drivers; absent pins stay low and undriven
        for (int p = 0; p < NUM_PIN; p++) begin
            if (OUT_MASK[p]) begin
                {st_next.pin_oe[p], st_next.pin_out[p]} = drive(st_reg.out_sel[p],
                    port_latch_bit[p], pin_direction_control[p], periph_out);
            end else begin
                st_next.pin_oe[p]  = 1'b0;
                st_next.pin_out[p] = 1'b0;
            end
        end

        // Other resets clear the lock but keep every selection
        if (soft_reset) begin
            st_next.seq      = SEQ_IDLE;
            st_next.locked   = 1'b0;
            st_next.clr_used = 1'b0;
            st_next.pready   = 1'b0;
            st_next.pslverr  = 1'b0;
            st_next.prdata   = '0;
        end
    end

    // =================================================================
    // State register; power-on reset loads the defaults
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg        <= '0;
            st_reg.in_sel <= IN_DEF;
            for (int p = 0; p < NUM_PIN; p++) begin
                st_reg.out_sel[p] <= OUT_DEF;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // Input routing
    psm_in_route #(
        .BIG_VARIANT (BIG_VARIANT)
    ) u_in_route (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (pin_in),
        .in_sel    (st_reg.in_sel),
        .periph_in (periph_in)
    );

    assign prdata  = st_reg.prdata;
    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign pin_out = st_reg.pin_out;
    assign pin_oe  = st_reg.pin_oe;

endmodule // psm_top
`default_nettype wire

//--- bench/psm_top_sva.sv
// Assertion checker for the pin select mux, bound to psm_top.
// Assumes one clk_sys domain and the one-wait-state APB answer.
`timescale 1ns/10ps
`default_nettype none
module psm_top_sva
    import psm_pkg::*;
#(
    parameter logic               BIG_VARIANT = 1'b1,
    parameter logic [NUM_SRC-1:0] SRC_AVAIL   = SRC_AVAIL_ALL
) (
    // Clock and resets
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               soft_reset,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Pins and peripherals
    input wire logic [NUM_PIN-1:0] pin_out,
    input wire logic [NUM_PIN-1:0] pin_oe,
    input wire logic [NUM_PIN-1:0] pin_direction_control,
    input wire psm_periph_out_s    periph_out,
    input wire psm_periph_in_s     periph_in
);
    // =================================================================
    // Common timing
    localparam logic [NUM_PIN-1:0] PMASK = BIG_VARIANT ? OUT_MASK_BIG : OUT_MASK_SMALL;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset || soft_reset);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_rd; pready && !pwrite; endsequence

    // =================================================================
    // Bus answer
    a_answer_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("no answer after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_unmapped_err: assert property (s_wait ##0 (paddr == 8'hFC) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    // =================================================================
    // Field widths
    a_in_width: assert property (s_rd ##0 (paddr >= ADDR_IN_LO && paddr <= ADDR_IN_HI)
        |-> prdata[31:5] == 27'h0) else $error("input selector upper bits set");
    a_out_width: assert property (s_rd ##0 (paddr >= ADDR_OUT_LO && paddr <= ADDR_OUT_HI)
        |-> prdata[31:4] == 28'h0) else $error("pin selector upper bits set");
    a_lock_width: assert property (s_rd ##0 (paddr == ADDR_LOCK)
        |-> prdata[31:1] == 31'h0) else $error("lock upper bits set");

    // =================================================================
    // Pins
    a_dir_follow: assert property (!$past(reset) && !$past(soft_reset)
        && $past(periph_out.ovr) == 4'h0
        |-> pin_oe == (~$past(pin_direction_control) & PMASK))
        else $error("pin enable not from direction");
    a_absent_quiet: assert property (((pin_out | pin_oe) & ~PMASK) == 24'h0)
        else $error("absent pin driven");
    a_reset_clear: assert property ($fell(reset) |-> !pready && pin_oe == 24'h0
        && periph_in == 8'h0) else $error("outputs not cleared by reset");
endmodule // psm_top_sva

bind psm_top psm_top_sva #(.BIG_VARIANT(BIG_VARIANT), .SRC_AVAIL(SRC_AVAIL)) u_sva (
    .clk_sys, .reset, .soft_reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .pin_out, .pin_oe, .pin_direction_control, .periph_out, .periph_in);
`default_nettype wire

//--- bench/psm_periph_model.sv
// Peripheral and pin model: registered peripheral outputs, pin levels.
// Assumes the bench sets source values, overrides and outside levels.
`timescale 1ns/10ps
`default_nettype none
module psm_periph_model
    import psm_pkg::*;
(
    // Clock
    input  wire logic [0:0]         clk_sys,
    // Bench controls
    input  wire logic [9:0]         src,
    input  wire logic [3:0]         ovr,
    input  wire logic [3:0]         ovr_oe,
    input  wire logic [NUM_PIN-1:0] ext_lvl,
    // Mux side
    input  wire logic [NUM_PIN-1:0] pin_out,
    input  wire logic [NUM_PIN-1:0] pin_oe,
    output psm_periph_out_s         periph_out,
    output logic [NUM_PIN-1:0]      pin_in
);
    // =================================================================
    // Peripherals change only on the clock, as real ones do
    always_ff @(posedge clk_sys) begin
        periph_out <= {src[0], src[1], src[5:2], src[6], src[7], src[8], src[9], ovr, ovr_oe};
    end

    // =================================================================
    // Wire level: the mux when it drives, else the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // psm_periph_model
`default_nettype wire

//--- bench/tb_peripheral_pin_select_mux.sv
// Testbench for the pin select mux: APB tasks and directed tests.
// Assumes the peripheral model drives periph_out and pin levels.
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_pin_select_mux
    import psm_pkg::*;
;
    // =================================================================
    // Signals
    logic               clk_sys = 1'b0, reset = 1'b1, soft_reset = 1'b0, one_shot = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, errv;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata, rdv;
    logic [NUM_PIN-1:0] pin_in, pin_out, pin_oe, ext_lvl = 24'h0, dir = 24'hFFFFFF;
    logic [10:0]        sv = 11'h0;
    logic [3:0]         ovr = 4'h0, ovr_oe = 4'h0;
    psm_periph_out_s    periph_out;
    psm_periph_in_s     periph_in;
    int                 fails = 0, cmp_count = 0;
    logic [4:0]         dflt [8] = '{5'h02, 5'h02, 5'h05, 5'h04, 5'h02, 5'h0D, 5'h0F, 5'h14};
    logic [4:0]         rcode [4] = '{5'h01, 5'h0D, 5'h14, 5'h1C};
    logic [23:0]        rpin [4] = '{24'h000002, 24'h002000, 24'h100000, 24'hFFFFFF};

    always #12.5 clk_sys = ~clk_sys;

    psm_top uut (.clk_sys, .reset, .soft_reset, .one_shot_lock_option(one_shot), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
        .pin_oe, .port_latch_bit({23'h0, sv[0]}), .pin_direction_control(dir),
        .periph_out, .periph_in);
    psm_periph_model model (.clk_sys, .src(sv[10:1]), .ovr, .ovr_oe, .ext_lvl, .pin_out,
        .pin_oe, .periph_out, .pin_in);

    // =================================================================
    // Tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next request never lands in this time step
        @(posedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdv);
    endtask
    task automatic keys;
        wr(ADDR_LOCK, 32'h55);
        wr(ADDR_LOCK, 32'hAA);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // =================================================================
    // Tests
    initial begin
        tick(6);
        reset <= 1'b0;
        tick(1);
        rdc(ADDR_LOCK, 32'h0, "lock_rst");
        for (int i = 0; i < 8; i++)
            rdc(ADDR_IN_LO + 8'(4 * i), 32'(dflt[i]), "in_default");
        rdc(ADDR_OUT_HI, 32'h0, "out_default");
        $display("test defaults done");
        wr(ADDR_IN_LO, 32'hFFFFFFFF);
        rdc(ADDR_IN_LO, 32'h1F, "in_width");
        wr(ADDR_OUT_LO + 8'h04, 32'hFFFFFFFF);
        rdc(ADDR_OUT_LO + 8'h04, 32'hF, "out_width");
        wr(ADDR_LOCK, 32'hFFFFFFFE);
        rdc(ADDR_LOCK, 32'h0, "lock_width");
        apb(1'b1, 8'hFC, 32'h1);
        chk("unmapped_err", 32'h1, 32'(errv));
        $display("test widths done");
        dir <= 24'hFFFFFE;
        for (int p = 0; p < 2; p++) begin
            sv <= p ? 11'h2AA : 11'h555;
            for (int c = 0; c < 16; c++) begin
                wr(ADDR_OUT_LO, 32'(c));
                tick(2);
                chk("pin_src", (c < 11) ? 32'(sv[c]) : 32'h0, 32'(pin_out[0]));
                chk("pin_dir", 32'h1, 32'(pin_oe[0]));
            end
        end
        ovr    <= 4'hF;
        ovr_oe <= 4'hA;
        for (int c = 3; c < 11; c++) begin
            wr(ADDR_OUT_LO, 32'(c));
            tick(2);
            chk("ovr_oe", (c > 6) ? 32'((4'hA >> (c - 7)) & 4'h1) : 32'h1, 32'(pin_oe[0]));
        end
        ovr <= 4'h0;
        wr(ADDR_OUT_LO, 32'h0);
        $display("test outputs done");
        dir <= 24'hFFFFFF;
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_IN_LO, 32'(rcode[t]));
            for (int v = 1; v >= 0; v--) begin
                ext_lvl <= v ? rpin[t] : ~rpin[t];
                tick(5);
                chk("in_route", 32'(v == 1 && t < 3), 32'(periph_in.edge_irq));
                chk("conv_default", 32'(ext_lvl[20]), 32'(periph_in.conv_trig));
            end
        end
        $display("test inputs done");
        wr(ADDR_LOCK, 32'h1);
        rdc(ADDR_LOCK, 32'h0, "lock_nokey");
        wr(ADDR_LOCK, 32'h55);
        wr(ADDR_IN_LO, 32'h3);
        wr(ADDR_LOCK, 32'hAA);
        wr(ADDR_LOCK, 32'h1);
        rdc(ADDR_LOCK, 32'h0, "lock_broken");
        keys;
        wr(ADDR_LOCK, 32'h1);
        rdc(ADDR_LOCK, 32'h1, "lock_set");
        wr(ADDR_IN_LO, 32'h7);
        wr(ADDR_OUT_LO, 32'h3);
        rdc(ADDR_IN_LO, 32'h3, "in_locked");
        rdc(ADDR_OUT_LO, 32'h0, "out_locked");
        keys;
        wr(ADDR_LOCK, 32'h0);
        rdc(ADDR_LOCK, 32'h0, "lock_clear");
        wr(ADDR_IN_LO, 32'h7);
        rdc(ADDR_IN_LO, 32'h7, "in_open");
        $display("test lock done");
        one_shot <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            keys;
            wr(ADDR_LOCK, 32'h1);
            keys;
            wr(ADDR_LOCK, 32'h0);
            rdc(ADDR_LOCK, 32'(r), "one_shot");
        end
        soft_reset <= 1'b1;
        tick(2);
        soft_reset <= 1'b0;
        tick(1);
        rdc(ADDR_LOCK, 32'h0, "soft_lock");
        rdc(ADDR_IN_LO, 32'h7, "soft_keep");
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        tick(1);
        rdc(ADDR_IN_LO, 32'h2, "por_restore");
        $display("test resets done");
        finish_test;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        tick(40000);
        fails++;
        finish_test;
    end
endmodule // tb_peripheral_pin_select_mux
`default_nettype wire
